// ==== hw/fecg_consts.vh ====
`ifndef FECG_CONSTS_VH
`define FECG_CONSTS_VH

// protection key word location and value
`define FECG_PROT_KEY_ADDR 12'h1fc
`define FECG_PROT_KEY 32'h87654321

// unlock key, decimal 23130
`define FECG_UNLOCK_KEY 32'h00005a5a

// check byte layout
`define FECG_CHK_ERASED 8'hff
`define FECG_CHK_USED_MASK 8'hc0
`define FECG_CHK_BITS 6

// control characters
`define FECG_CH_ESC 8'h1b
`define FECG_CH_CR 8'h0d
`define FECG_CH_LF 8'h0a
`define FECG_CH_SPACE 8'h20
`define FECG_CH_ZERO 8'h30
`define FECG_CH_NINE 8'h39

// command letters
`define FECG_CMD_UNLOCK 8'h55
`define FECG_CMD_BAUD 8'h42
`define FECG_CMD_ECHO 8'h41
`define FECG_CMD_WRRAM 8'h57
`define FECG_CMD_READ 8'h52
`define FECG_CMD_PREP 8'h50
`define FECG_CMD_COPY 8'h43
`define FECG_CMD_GO 8'h47
`define FECG_CMD_ERASE 8'h45
`define FECG_CMD_BLANK 8'h49
`define FECG_CMD_PARTID 8'h4a
`define FECG_CMD_VERSION 8'h4b
`define FECG_CMD_COMPARE 8'h4d

// reply codes, ascii characters
`define FECG_RPL_SUCCESS 8'h30
`define FECG_RPL_INVALID 8'h31
`define FECG_RPL_BADKEY 8'h32
`define FECG_RPL_LOCKED 8'h33
`define FECG_RPL_PROTECTED 8'h34

`endif

// ==== hw/fecg_gate.v ====
// Notes on behaviour
// - every word read from the array is decoded and single-bit errors corrected.
// - data words are encoded on the way into the array, no software action.
// - check bytes live in an internal store software cannot reach.
// - one check byte per aligned four-byte group, in group order.
// - a read fetches the whole 128-bit line plus its check bytes first.
// - each program write stores its check byte in the same operation.
// - erasing a sector also erases all of its check bytes.
// - a programmed check byte cannot be rewritten before its sector is erased.
// - protection is on when word 0x1fc of sector 0 holds the key.
// - while protected, debug port and external boot are disabled.
// - while protected, read, write-RAM, go and copy get the protected reply.
// - while protected, serial erase must cover all user sectors.
// - application-called flash routines ignore protection.
// - the protection key is sampled once after every reset, by the boot read.
// - an unrecognised command letter gets the unknown-command reply.
// - commands and replies travel as ascii characters.
// - success only after full completion, except baud, write-RAM, read, go.
// - letters U B A W R P C G E I J K M decode to their commands.
// - unlock with 23130 enables copy, erase and go; other keys get bad-key.
// - an escape character abandons the command and waits for a new one.
`timescale 1ns/1ps
`include "fecg_consts.vh"

module fecg_gate #(
  parameter ADDR_W = 13,
  parameter NUM_SECTORS = 8,
  parameter SECTOR_SHIFT = 10
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // core read port, one 128-bit line
  input wire rdReq,
  input wire [ADDR_W-3:0] rdLine,
  output reg rdValid,
  output reg [127:0] rdData,
  output reg rdCorrected,
  output reg rdUncorrectable,
  // application program and erase port
  input wire progReq,
  input wire [ADDR_W-1:0] progGroup,
  input wire [31:0] progData,
  output reg progDone,
  output reg progRefused,
  input wire eraseReq,
  input wire [4:0] eraseSector,
  output reg eraseDone,
  output reg busy,
  // flash array
  output reg arrayRdEn,
  output reg [ADDR_W-3:0] arrayRdLine,
  input wire [127:0] arrayRdData,
  output reg arrayWrEn,
  output reg [ADDR_W-1:0] arrayWrGroup,
  output reg [31:0] arrayWrData,
  output reg arrayEraseEn,
  output reg [4:0] arrayEraseSector,
  // protection state
  output reg protectOn,
  output reg debugDisable,
  output reg extBootDisable,
  // serial programming characters
  input wire rxValid,
  input wire [7:0] rxChar,
  output reg txValid,
  output reg [7:0] txChar,
  // hand-off to firmware
  output reg dispValid,
  output reg [7:0] dispLetter,
  output reg [31:0] dispArg0,
  output reg [31:0] dispArg1,
  input wire cmdDone,
  input wire [7:0] cmdDoneCode
);

  localparam GROUPS = 1 << ADDR_W;
  localparam [ADDR_W-1:0] SECTOR_LAST_CNT = {ADDR_W{1'b1}} >> (ADDR_W - SECTOR_SHIFT);
  localparam [31:0] LAST_SECTOR = NUM_SECTORS - 1;
  localparam [11:0] KEY_ADDR = `FECG_PROT_KEY_ADDR;

  // flash-side states
  localparam [4:0] ST_BOOT = 5'h01;
  localparam [4:0] ST_IDLE = 5'h02;
  localparam [4:0] ST_RDREQ = 5'h04;
  localparam [4:0] ST_RDDAT = 5'h08;
  localparam [4:0] ST_ERASE = 5'h10;

  // command handler states
  localparam [2:0] H_LETTER = 3'h1;
  localparam [2:0] H_ARGS = 3'h2;
  localparam [2:0] H_WAIT = 3'h4;

  // hamming check bits over 32 data bits, positions skip powers of two
  function [5:0] hamEnc;
    input [31:0] d;
    integer p;
    integer j;
    integer k;
    begin
      hamEnc = 6'h00;
      k = 0;
      for (p = 1; p < 39; p = p + 1)
      begin
        if ((p & (p - 1)) != 0)
        begin
          for (j = 0; j < 6; j = j + 1)
          begin
            if (((p >> j) & 1) == 1)
              hamEnc[j] = hamEnc[j] ^ d[k];
          end
          k = k + 1;
        end
      end
    end
  endfunction

  // returns {uncorrectable, corrected, data}
  function [33:0] hamDec;
    input [31:0] d;
    input [7:0] c;
    reg [5:0] syn;
    reg [31:0] fixed;
    reg hit;
    integer p;
    integer k;
    begin
      syn = c[5:0] ^ hamEnc(d);
      fixed = d;
      hit = 1'b0;
      k = 0;
      if (d == 32'hffffffff && c == `FECG_CHK_ERASED)
        hamDec = {2'b00, d};
      else if (syn == 6'h00)
        hamDec = {2'b00, d};
      else if ((syn & (syn - 6'h01)) == 6'h00)
        hamDec = {2'b01, d}; // check bit itself flipped
      else
      begin
        for (p = 1; p < 39; p = p + 1)
        begin
          if ((p & (p - 1)) != 0)
          begin
            if (p == syn)
            begin
              fixed[k] = ~fixed[k];
              hit = 1'b1;
            end
            k = k + 1;
          end
        end
        if (hit)
          hamDec = {2'b01, fixed};
        else
          hamDec = {2'b10, d};
      end
    end
  endfunction

  // internal check store, never visible on a port
  reg [7:0] checkMem [0:GROUPS-1];

  reg [4:0] state_reg;
  reg bootRead_reg;
  reg [31:0] lineChk_reg;
  reg [ADDR_W-1:0] eraseIdx_reg;
  reg [ADDR_W-1:0] eraseCnt_reg;
  reg [2:0] hState_reg;
  reg [7:0] letter_reg;
  reg [31:0] arg0_reg;
  reg [31:0] arg1_reg;
  reg argIdx_reg;
  reg seenDigit_reg;
  reg unlocked_reg;

  // decode of the fetched line, one decoder per four-byte group
  wire [127:0] decData;
  wire [3:0] decCorr;
  wire [3:0] decUnc;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : dec
      wire [33:0] res;
      assign res = hamDec(arrayRdData[32*g+31:32*g], lineChk_reg[8*g+7:8*g]);
      assign decData[32*g+31:32*g] = res[31:0];
      assign decCorr[g] = res[32];
      assign decUnc[g] = res[33];
    end
  endgenerate

  // erase start index and key location
  wire [31:0] eraseBase = {27'h0, eraseSector} << SECTOR_SHIFT;
  wire [ADDR_W-3:0] keyLine = {{(ADDR_W-10){1'b0}}, KEY_ADDR[11:4]};
  wire [1:0] keyWord = KEY_ADDR[3:2];
  wire [31:0] keyDec = decData[{keyWord, 5'h00} +: 32];

  // flash-side sequencer: boot key read, line reads, program, erase
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_BOOT;
      bootRead_reg <= 1'b0;
      lineChk_reg <= 32'h0;
      eraseIdx_reg <= {ADDR_W{1'b0}};
      eraseCnt_reg <= {ADDR_W{1'b0}};
      rdValid <= 1'b0;
      rdData <= 128'h0;
      rdCorrected <= 1'b0;
      rdUncorrectable <= 1'b0;
      progDone <= 1'b0;
      progRefused <= 1'b0;
      eraseDone <= 1'b0;
      busy <= 1'b1;
      arrayRdEn <= 1'b0;
      arrayRdLine <= {(ADDR_W-2){1'b0}};
      arrayWrEn <= 1'b0;
      arrayWrGroup <= {ADDR_W{1'b0}};
      arrayWrData <= 32'h0;
      arrayEraseEn <= 1'b0;
      arrayEraseSector <= 5'h00;
      protectOn <= 1'b0;
      debugDisable <= 1'b0;
      extBootDisable <= 1'b0;
    end
    else
    begin
      rdValid <= 1'b0;
      progDone <= 1'b0;
      progRefused <= 1'b0;
      eraseDone <= 1'b0;
      arrayRdEn <= 1'b0;
      arrayWrEn <= 1'b0;
      arrayEraseEn <= 1'b0;
      case (state_reg)
        ST_BOOT:
        begin
          // one key read after reset only
          arrayRdEn <= 1'b1;
          arrayRdLine <= keyLine;
          lineChk_reg <= {checkMem[{keyLine, 2'd3}], checkMem[{keyLine, 2'd2}],
                          checkMem[{keyLine, 2'd1}], checkMem[{keyLine, 2'd0}]};
          bootRead_reg <= 1'b1;
          state_reg <= ST_RDREQ;
        end
        ST_IDLE:
        begin
          if (eraseReq)
          begin
            // app erase, no protection check here
            arrayEraseEn <= 1'b1;
            arrayEraseSector <= eraseSector;
            eraseIdx_reg <= eraseBase[ADDR_W-1:0];
            eraseCnt_reg <= {ADDR_W{1'b0}};
            busy <= 1'b1;
            state_reg <= ST_ERASE;
          end
          else if (progReq)
          begin
            if (checkMem[progGroup] != `FECG_CHK_ERASED)
              progRefused <= 1'b1;
            else
            begin
              arrayWrEn <= 1'b1;
              arrayWrGroup <= progGroup;
              arrayWrData <= progData;
              progDone <= 1'b1;
            end
          end
          else if (rdReq)
          begin
            arrayRdEn <= 1'b1;
            arrayRdLine <= rdLine;
            lineChk_reg <= {checkMem[{rdLine, 2'd3}], checkMem[{rdLine, 2'd2}],
                            checkMem[{rdLine, 2'd1}], checkMem[{rdLine, 2'd0}]};
            bootRead_reg <= 1'b0;
            busy <= 1'b1;
            state_reg <= ST_RDREQ;
          end
        end
        ST_RDREQ:
          state_reg <= ST_RDDAT;
        ST_RDDAT:
        begin
          if (bootRead_reg)
          begin
            protectOn <= (keyDec == `FECG_PROT_KEY);
            debugDisable <= (keyDec == `FECG_PROT_KEY);
            extBootDisable <= (keyDec == `FECG_PROT_KEY);
          end
          else
          begin
            rdValid <= 1'b1;
            rdData <= decData;
            rdCorrected <= |decCorr;
            rdUncorrectable <= |decUnc;
          end
          busy <= 1'b0;
          state_reg <= ST_IDLE;
        end
        ST_ERASE:
        begin
          eraseIdx_reg <= eraseIdx_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
          eraseCnt_reg <= eraseCnt_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
          if (eraseCnt_reg == SECTOR_LAST_CNT)
          begin
            eraseDone <= 1'b1;
            busy <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // check store writes: program stores code, erase wipes one byte a cycle
  always @(posedge clock)
  begin
    if (!rst && state_reg == ST_ERASE)
      checkMem[eraseIdx_reg] <= `FECG_CHK_ERASED;
    else if (!rst && state_reg == ST_IDLE && !eraseReq && progReq &&
             checkMem[progGroup] == `FECG_CHK_ERASED)
      checkMem[progGroup] <= {2'b00, hamEnc(progData)};
  end

  // character classes
  wire isDigit = rxChar >= `FECG_CH_ZERO && rxChar <= `FECG_CH_NINE;
  wire [31:0] digitVal = {28'h0, rxChar[3:0]};
  wire [31:0] curArg = argIdx_reg ? arg1_reg : arg0_reg;
  wire [31:0] argNext = {curArg[28:0], 3'h0} + {curArg[30:0], 1'b0} + digitVal;
  wire isKnown = letter_reg == `FECG_CMD_UNLOCK || letter_reg == `FECG_CMD_BAUD ||
                 letter_reg == `FECG_CMD_ECHO || letter_reg == `FECG_CMD_WRRAM ||
                 letter_reg == `FECG_CMD_READ || letter_reg == `FECG_CMD_PREP ||
                 letter_reg == `FECG_CMD_COPY || letter_reg == `FECG_CMD_GO ||
                 letter_reg == `FECG_CMD_ERASE || letter_reg == `FECG_CMD_BLANK ||
                 letter_reg == `FECG_CMD_PARTID || letter_reg == `FECG_CMD_VERSION ||
                 letter_reg == `FECG_CMD_COMPARE;
  wire isBlocked = letter_reg == `FECG_CMD_READ || letter_reg == `FECG_CMD_WRRAM ||
                   letter_reg == `FECG_CMD_GO || letter_reg == `FECG_CMD_COPY;
  wire needsKey = letter_reg == `FECG_CMD_COPY || letter_reg == `FECG_CMD_ERASE ||
                  letter_reg == `FECG_CMD_GO;
  wire noReply = letter_reg == `FECG_CMD_BAUD || letter_reg == `FECG_CMD_WRRAM ||
                 letter_reg == `FECG_CMD_READ || letter_reg == `FECG_CMD_GO;
  wire eraseAll = arg0_reg == 32'h0 && arg1_reg == LAST_SECTOR;

  // serial command handler, one ascii character per rxValid
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hState_reg <= H_LETTER;
      letter_reg <= 8'h00;
      arg0_reg <= 32'h0;
      arg1_reg <= 32'h0;
      argIdx_reg <= 1'b0;
      seenDigit_reg <= 1'b0;
      unlocked_reg <= 1'b0;
      txValid <= 1'b0;
      txChar <= 8'h00;
      dispValid <= 1'b0;
      dispLetter <= 8'h00;
      dispArg0 <= 32'h0;
      dispArg1 <= 32'h0;
    end
    else
    begin
      txValid <= 1'b0;
      dispValid <= 1'b0;
      if (rxValid && rxChar == `FECG_CH_ESC)
        hState_reg <= H_LETTER;
      else
      begin
        case (hState_reg)
          H_LETTER:
          begin
            if (rxValid && rxChar != `FECG_CH_CR && rxChar != `FECG_CH_LF)
            begin
              letter_reg <= rxChar;
              arg0_reg <= 32'h0;
              arg1_reg <= 32'h0;
              argIdx_reg <= 1'b0;
              seenDigit_reg <= 1'b0;
              hState_reg <= H_ARGS;
            end
          end
          H_ARGS:
          begin
            if (rxValid && isDigit)
            begin
              if (argIdx_reg)
                arg1_reg <= argNext;
              else
                arg0_reg <= argNext;
              seenDigit_reg <= 1'b1;
            end
            else if (rxValid && rxChar == `FECG_CH_SPACE && seenDigit_reg)
            begin
              argIdx_reg <= 1'b1;
              seenDigit_reg <= 1'b0;
            end
            else if (rxValid && rxChar == `FECG_CH_LF)
            begin
              hState_reg <= H_LETTER;
              if (!isKnown)
              begin
                txValid <= 1'b1;
                txChar <= `FECG_RPL_INVALID;
              end
              else if (letter_reg == `FECG_CMD_UNLOCK)
              begin
                txValid <= 1'b1;
                if (arg0_reg == `FECG_UNLOCK_KEY)
                begin
                  unlocked_reg <= 1'b1;
                  txChar <= `FECG_RPL_SUCCESS;
                end
                else
                  txChar <= `FECG_RPL_BADKEY;
              end
              else if (protectOn && isBlocked)
              begin
                txValid <= 1'b1;
                txChar <= `FECG_RPL_PROTECTED;
              end
              else if (needsKey && !unlocked_reg)
              begin
                txValid <= 1'b1;
                txChar <= `FECG_RPL_LOCKED;
              end
              else if (letter_reg == `FECG_CMD_ERASE && protectOn && !eraseAll)
              begin
                txValid <= 1'b1;
                txChar <= `FECG_RPL_PROTECTED;
              end
              else
              begin
                dispValid <= 1'b1;
                dispLetter <= letter_reg;
                dispArg0 <= arg0_reg;
                dispArg1 <= arg1_reg;
                if (!noReply)
                  hState_reg <= H_WAIT;
              end
            end
          end
          H_WAIT:
          begin
            if (cmdDone)
            begin
              txValid <= 1'b1;
              txChar <= cmdDoneCode;
              hState_reg <= H_LETTER;
            end
          end
          default:
            hState_reg <= H_LETTER;
        endcase
      end
    end
  end

endmodule

// ==== test/fecg_flash_model.sv ====
`timescale 1ns/1ps
module fecg_flash_model (
  // clock
  input wire clock,
  // read side
  input wire arrayRdEn,
  input wire [10:0] arrayRdLine,
  output logic [127:0] arrayRdData,
  // program and erase side
  input wire arrayWrEn,
  input wire [12:0] arrayWrGroup,
  input wire [31:0] arrayWrData,
  input wire arrayEraseEn,
  input wire [4:0] arrayEraseSector,
  // bit errors added to read data
  input wire [127:0] flipMask
);
  logic [127:0] mem [0:2047];
  // erased array at start
  initial
  begin
    for (int i = 0; i < 2048; i++)
      mem[i] = '1;
    arrayRdData = '0;
  end
  // data the cycle after the strobe, scrambled otherwise
  always @(posedge clock)
  begin
    if (arrayRdEn)
      arrayRdData <= mem[arrayRdLine] ^ flipMask;
    else
      arrayRdData <= ~arrayRdData;
    if (arrayWrEn)
      mem[arrayWrGroup[12:2]][arrayWrGroup[1:0]*32 +: 32] <= arrayWrData;
    if (arrayEraseEn)
      for (int i = 0; i < 256; i++)
        mem[{arrayEraseSector[2:0], 8'h00} + i] <= '1;
  end
endmodule

// ==== test/fecg_gate_asserts.sv ====
`timescale 1ns/1ps
module fecg_gate_asserts #(
  parameter ADDR_W = 13
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // core and application side
  input wire rdReq,
  input wire [ADDR_W-3:0] rdLine,
  input wire rdValid,
  input wire busy,
  input wire progReq,
  input wire [ADDR_W-1:0] progGroup,
  input wire [31:0] progData,
  input wire progDone,
  input wire progRefused,
  input wire eraseReq,
  input wire [4:0] eraseSector,
  // array side
  input wire arrayRdEn,
  input wire [ADDR_W-3:0] arrayRdLine,
  input wire arrayWrEn,
  input wire [ADDR_W-1:0] arrayWrGroup,
  input wire [31:0] arrayWrData,
  input wire arrayEraseEn,
  input wire [4:0] arrayEraseSector,
  // protection and serial side
  input wire protectOn,
  input wire debugDisable,
  input wire extBootDisable,
  input wire txValid,
  input wire [7:0] txChar,
  input wire cmdDone,
  input wire [7:0] cmdDoneCode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // requests taken while idle
  sequence rdTake; rdReq && !busy && !progReq && !eraseReq; endsequence
  sequence progTake; progReq && !busy && !eraseReq; endsequence
  sequence eraseTake; eraseReq && !busy; endsequence
  sequence rdWalk; arrayRdEn && busy ##1 !arrayRdEn ##1 rdValid; endsequence
  a_read_walk: assert property (rdTake |=> rdWalk)
  else $error("read walk broken");
  a_read_line: assert property (rdTake |=> arrayRdLine == $past(rdLine))
  else $error("wrong line fetched");
  a_prog_answer: assert property (progTake |=> progDone != progRefused)
  else $error("program not answered");
  a_prog_strobe: assert property (progDone |-> arrayWrEn && arrayWrGroup == $past(progGroup)
    && arrayWrData == $past(progData))
  else $error("program strobe wrong");
  a_refuse_nowrite: assert property (progRefused |-> !arrayWrEn)
  else $error("refused group written");
  a_erase_start: assert property (eraseTake |=> arrayEraseEn
    && arrayEraseSector == $past(eraseSector) ##1 busy [*8])
  else $error("erase start wrong");
  a_prot_mirror: assert property (protectOn == debugDisable && protectOn == extBootDisable)
  else $error("protection outputs differ");
  a_prot_fixed: assert property ($changed(protectOn) |-> $past(arrayRdEn, 2)
    && $past(arrayRdLine, 2) == 'h1f)
  else $error("protection changed outside boot");
  a_tx_ascii: assert property (txValid |-> txChar >= 8'h30 && txChar <= 8'h34 ##1 !txValid)
  else $error("reply not ascii pulse");
  a_done_reply: assert property (cmdDone |=> txValid && txChar == $past(cmdDoneCode))
  else $error("completion reply wrong");
endmodule

bind fecg_gate fecg_gate_asserts #(.ADDR_W(ADDR_W)) i_chk (
  .clock(clock), .rst(rst), .rdReq(rdReq), .rdLine(rdLine), .rdValid(rdValid), .busy(busy),
  .progReq(progReq), .progGroup(progGroup), .progData(progData), .progDone(progDone),
  .progRefused(progRefused), .eraseReq(eraseReq), .eraseSector(eraseSector),
  .arrayRdEn(arrayRdEn), .arrayRdLine(arrayRdLine), .arrayWrEn(arrayWrEn),
  .arrayWrGroup(arrayWrGroup), .arrayWrData(arrayWrData), .arrayEraseEn(arrayEraseEn),
  .arrayEraseSector(arrayEraseSector), .protectOn(protectOn), .debugDisable(debugDisable),
  .extBootDisable(extBootDisable), .txValid(txValid), .txChar(txChar), .cmdDone(cmdDone),
  .cmdDoneCode(cmdDoneCode));

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  typedef struct {string s; logic [7:0] tx; logic disp;} fecg_row_t;
  logic clock, rst, rdReq, rdValid, rdCorrected, rdUncorrectable, progReq, progDone;
  logic progRefused, eraseReq, eraseDone, busy, arrayRdEn, arrayWrEn, arrayEraseEn;
  logic protectOn, debugDisable, extBootDisable, rxValid, txValid, dispValid, cmdDone;
  logic [10:0] rdLine, arrayRdLine;
  logic [12:0] progGroup, arrayWrGroup;
  logic [31:0] progData, arrayWrData, dispArg0, dispArg1;
  logic [4:0] eraseSector, arrayEraseSector;
  logic [7:0] rxChar, txChar, dispLetter, cmdDoneCode;
  logic [127:0] rdData, arrayRdData, flipMask;
  int err_total = 0;
  int checks_done = 0;
  // command line, reply expected, hand-off expected
  fecg_row_t rows [0:23] = '{
    '{"X\n", 8'h31, 1'b0}, '{"U 1\n", 8'h32, 1'b0}, '{"E 0 7\n", 8'h33, 1'b0},
    '{"U 23130\n", 8'h30, 1'b0}, '{"B 9600 1\n", 8'h00, 1'b1},
    '{"A 0\n", 8'h30, 1'b1}, '{"W 0 4\n", 8'h00, 1'b1}, '{"R 0 4\n", 8'h00, 1'b1},
    '{"P 2 3\n", 8'h30, 1'b1}, '{"C 0 0 4\n", 8'h30, 1'b1}, '{"G 0 0\n", 8'h00, 1'b1},
    '{"E 2 3\n", 8'h30, 1'b1}, '{"I 0 0\n", 8'h30, 1'b1}, '{"J\n", 8'h30, 1'b1},
    '{"K\n", 8'h30, 1'b1}, '{"M 0 0 4\n", 8'h30, 1'b1}, '{"E 2\033X\n", 8'h31, 1'b0},
    '{"U 23130\n", 8'h30, 1'b0}, '{"R 0 4\n", 8'h34, 1'b0}, '{"W 0 4\n", 8'h34, 1'b0},
    '{"G 0 0\n", 8'h34, 1'b0}, '{"C 0 0 4\n", 8'h34, 1'b0}, '{"E 2 3\n", 8'h34, 1'b0},
    '{"E 0 7\n", 8'h30, 1'b1}};

  fecg_gate i_dut (
    .clock(clock), .rst(rst), .rdReq(rdReq), .rdLine(rdLine), .rdValid(rdValid),
    .rdData(rdData), .rdCorrected(rdCorrected), .rdUncorrectable(rdUncorrectable),
    .progReq(progReq), .progGroup(progGroup), .progData(progData), .progDone(progDone),
    .progRefused(progRefused), .eraseReq(eraseReq), .eraseSector(eraseSector),
    .eraseDone(eraseDone), .busy(busy), .arrayRdEn(arrayRdEn), .arrayRdLine(arrayRdLine),
    .arrayRdData(arrayRdData), .arrayWrEn(arrayWrEn), .arrayWrGroup(arrayWrGroup),
    .arrayWrData(arrayWrData), .arrayEraseEn(arrayEraseEn),
    .arrayEraseSector(arrayEraseSector), .protectOn(protectOn), .debugDisable(debugDisable),
    .extBootDisable(extBootDisable), .rxValid(rxValid), .rxChar(rxChar), .txValid(txValid),
    .txChar(txChar), .dispValid(dispValid), .dispLetter(dispLetter), .dispArg0(dispArg0),
    .dispArg1(dispArg1), .cmdDone(cmdDone), .cmdDoneCode(cmdDoneCode));
  fecg_flash_model i_flash (
    .clock(clock), .arrayRdEn(arrayRdEn), .arrayRdLine(arrayRdLine), .arrayRdData(arrayRdData),
    .arrayWrEn(arrayWrEn), .arrayWrGroup(arrayWrGroup), .arrayWrData(arrayWrData),
    .arrayEraseEn(arrayEraseEn), .arrayEraseSector(arrayEraseSector), .flipMask(flipMask));

  // 100 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task tick;
    @(posedge clock);
  endtask

  task finish_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task check(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function logic sig(input int w);
    case (w)
      0: return rdValid;
      1: return eraseDone;
      2: return !busy;
      3: return txValid;
      default: return dispValid;
    endcase
  endfunction

  // bounded wait, a miss ends the run
  task wait_for(input int w, input int lim);
    int n;
    n = 0;
    do
    begin
      tick;
      n++;
    end
    while (sig(w) !== 1'b1 && n < lim);
    check(sig(w), 1'b1);
    if (sig(w) !== 1'b1)
      finish_test;
  endtask

  task boot;
    rst <= 1'b1;
    repeat (2) tick;
    rst <= 1'b0;
    wait_for(2, 8);
  endtask

  task send(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      rxValid <= 1'b1;
      rxChar <= s[i];
      tick;
    end
    rxValid <= 1'b0;
  endtask

  task run_row(input fecg_row_t r);
    send(r.s);
    if (r.disp)
    begin
      wait_for(4, 4);
      check(dispLetter, r.s[0]);
    end
    if (r.disp && r.tx != 8'h00)
    begin
      cmdDone <= 1'b1;
      cmdDoneCode <= r.tx;
      tick;
      cmdDone <= 1'b0;
    end
    if (r.tx != 8'h00)
    begin
      wait_for(3, 4);
      check(txChar, r.tx);
    end
    else
      repeat (3)
      begin
        tick;
        check(txValid, 1'b0);
      end
  endtask

  task read_line(input logic [10:0] ln, input logic [127:0] flip, input logic [127:0] exp,
    input logic fix, input logic unc);
    flipMask <= flip;
    rdReq <= 1'b1;
    rdLine <= ln;
    tick;
    rdReq <= 1'b0;
    wait_for(0, 6);
    check(rdData, exp);
    check(rdCorrected, fix);
    check(rdUncorrectable, unc);
    flipMask <= '0;
  endtask

  task prog(input logic [12:0] g, input logic [31:0] d, input logic ok);
    progReq <= 1'b1;
    progGroup <= g;
    progData <= d;
    tick;
    progReq <= 1'b0;
    tick;
    check({progDone, progRefused}, {ok, !ok});
    if (ok)
      check({arrayWrGroup, arrayWrData}, {g, d});
  endtask

  // main sequence
  initial
  begin
    {rst, rdReq, progReq, eraseReq, rxValid, cmdDone} = 6'h20;
    {rdLine, progGroup, progData, eraseSector, rxChar, cmdDoneCode, flipMask} = '0;
    for (int i = 0; i < 8192; i++)
      i_dut.checkMem[i] = 8'hff;
    boot;
    check(protectOn, 1'b0);
    for (int i = 0; i < 17; i++)
      run_row(rows[i]);
    run_row(fecg_row_t'{"P 12 345\r\n", 8'h30, 1'b1});
    check({dispArg0, dispArg1}, {32'd12, 32'd345});
    read_line(11'h01f, '0, '1, 1'b0, 1'b0);
    for (int g = 0; g < 4; g++)
      prog(13'h0014 + g, 32'h12345670 + g, 1'b1);
    prog(13'h0014, 32'h00000000, 1'b0);
    read_line(11'h005, 128'h1 << 37, {32'h12345673, 32'h12345672, 32'h12345671,
      32'h12345670}, 1'b1, 1'b0);
    read_line(11'h005, '0, {32'h12345673, 32'h12345672, 32'h12345671,
      32'h12345670}, 1'b0, 1'b0);
    read_line(11'h005, 128'h04000004, {32'h12345673, 32'h12345672, 32'h12345671,
      32'h16345674}, 1'b0, 1'b1);
    eraseReq <= 1'b1;
    eraseSector <= 5'h00;
    tick;
    eraseReq <= 1'b0;
    tick;
    check({arrayEraseEn, arrayEraseSector}, 6'h20);
    wait_for(1, 1100);
    prog(13'h0014, 32'h00000000, 1'b1);
    prog(13'h007f, 32'h87654321, 1'b1);
    check(protectOn, 1'b0);
    boot;
    check({protectOn, debugDisable, extBootDisable}, 3'h7);
    for (int i = 17; i < 24; i++)
      run_row(rows[i]);
    prog(13'h0015, 32'h00000005, 1'b1);
    finish_test;
  end
endmodule
